// ==== design/rad_pkg.sv ====
// Shared constants and types of the execution datapath
package rad_pkg;
   localparam int unsigned INSTR_W = 14;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FADDR_W = 7;
   localparam int unsigned PC_W = 13;
   // Instruction cycle figures at the documented input rate
   localparam int unsigned ICYCLE_NS = 200;
   localparam int unsigned CLOCK_NS = 8;
   localparam int unsigned ICYCLE_CLKS = ICYCLE_NS / CLOCK_NS;
   // Status register layout and special register file addresses
   localparam int unsigned FLAG_CARRY = 0;
   localparam int unsigned FLAG_NIBBLE = 1;
   localparam int unsigned FLAG_ZERO = 2;
   localparam logic [6:0] ADDR_INDIRECT = 7'h00;
   localparam logic [6:0] ADDR_PCL = 7'h02;
   localparam logic [6:0] ADDR_STATUS = 7'h03;
   localparam logic [6:0] ADDR_FSR = 7'h04;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [13:0] NOP_WORD = 14'h0000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] NIB_ONES = 4'hf;

   typedef enum logic [3:0] {
      RAD_OP_PASS, RAD_OP_ADD, RAD_OP_SUB, RAD_OP_AND, RAD_OP_IOR, RAD_OP_XOR,
      RAD_OP_COM, RAD_OP_INC, RAD_OP_DEC, RAD_OP_RLF, RAD_OP_RRF, RAD_OP_SWAP,
      RAD_OP_CLR
   } rad_op_e;

   // Decoded execute request
   typedef struct packed {
      rad_op_e op;
      logic use_lit;
      logic to_file;
      logic wr_c;
      logic wr_dc;
      logic wr_z;
      logic jump;
      logic [7:0] lit;
      logic [6:0] faddr;
      logic [12:0] target;
   } rad_ctl_s;

   // Flag triple out of the arithmetic unit
   typedef struct packed {
      logic z;
      logic dc;
      logic c;
   } rad_flags_s;
endpackage

// ==== design/rad_alu.sv ====
// Eight bit two's complement arithmetic and logic unit
`timescale 1ns/100ps
`default_nettype none
module rad_alu #(
   parameter int unsigned WIDTH = rad_pkg::DATA_W
) (
   input wire rad_pkg::rad_op_e op,
   input wire logic [WIDTH-1:0] acc,
   input wire logic [WIDTH-1:0] opnd,
   input wire logic carry_in,
   output logic [WIDTH-1:0] result,
   output rad_pkg::rad_flags_s flags
);
   // Full-width add with carry in in one step; carry out lands in the top bit
   function automatic logic [WIDTH:0] add_c(input logic [WIDTH-1:0] a,
                                           input logic [WIDTH-1:0] b, input logic ci);
      add_c = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, ci};
   endfunction

   wire logic sub_op = (op == rad_pkg::RAD_OP_SUB);
   // Subtract as operand plus inverted accumulator plus one
   wire logic [WIDTH-1:0] addend = sub_op ? ~acc : acc;
   wire logic [WIDTH:0] sum = add_c(opnd, addend, sub_op);
   wire logic [4:0] low_sum = {1'b0, opnd[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub_op};

   always_comb begin
      result = opnd;
      unique case (op)
         rad_pkg::RAD_OP_PASS: result = opnd;
         rad_pkg::RAD_OP_ADD, rad_pkg::RAD_OP_SUB: result = sum[WIDTH-1:0];
         rad_pkg::RAD_OP_AND: result = acc & opnd;
         rad_pkg::RAD_OP_IOR: result = acc | opnd;
         rad_pkg::RAD_OP_XOR: result = acc ^ opnd;
         rad_pkg::RAD_OP_COM: result = ~opnd;
         rad_pkg::RAD_OP_INC: result = opnd + {{(WIDTH-1){1'b0}}, 1'b1};
         rad_pkg::RAD_OP_DEC: result = opnd - {{(WIDTH-1){1'b0}}, 1'b1};
         rad_pkg::RAD_OP_RLF: result = {opnd[WIDTH-2:0], carry_in};
         rad_pkg::RAD_OP_RRF: result = {carry_in, opnd[WIDTH-1:1]};
         rad_pkg::RAD_OP_SWAP: result = {opnd[3:0], opnd[WIDTH-1:4]};
         rad_pkg::RAD_OP_CLR: result = '0;
         default: result = opnd;
      endcase
   end

   // Flags: carry out of bit 7 or shifted-out bit, nibble carry out of bit 3
   always_comb begin
      flags.z = (result == '0);
      flags.dc = low_sum[4];
      flags.c = sum[WIDTH];
      if (op == rad_pkg::RAD_OP_RLF) begin
         flags.c = opnd[WIDTH-1];
      end else if (op == rad_pkg::RAD_OP_RRF) begin
         flags.c = opnd[0];
      end
   end
endmodule
`default_nettype wire

// ==== design/rad_decode.sv ====
// Instruction word decoder for the execute stage
`timescale 1ns/100ps
`default_nettype none
module rad_decode (
   input wire logic [rad_pkg::INSTR_W-1:0] instr,
   output rad_pkg::rad_ctl_s ctl
);
   wire logic [1:0] grp = instr[13:12];
   wire logic [3:0] sub = instr[11:8];

   // Byte ops (00), jumps (10), literal ops (11); bit ops (01) copy the addressed file into the accumulator
   always_comb begin
      ctl = '0;
      ctl.op = rad_pkg::RAD_OP_PASS;
      ctl.faddr = instr[6:0];
      ctl.lit = instr[7:0];
      ctl.target = {2'b00, instr[10:0]};
      ctl.to_file = instr[7];
      if (grp == 2'b00) begin
         unique case (sub)
            4'h0: ctl.op = rad_pkg::RAD_OP_PASS;
            4'h1: begin
               ctl.op = rad_pkg::RAD_OP_CLR;
               ctl.wr_z = 1'b1;
            end
            4'h2: begin
               ctl.op = rad_pkg::RAD_OP_SUB;
               {ctl.wr_c, ctl.wr_dc, ctl.wr_z} = 3'b111;
            end
            4'h3: begin
               ctl.op = rad_pkg::RAD_OP_DEC;
               ctl.wr_z = 1'b1;
            end
            4'h4: begin
               ctl.op = rad_pkg::RAD_OP_IOR;
               ctl.wr_z = 1'b1;
            end
            4'h5: begin
               ctl.op = rad_pkg::RAD_OP_AND;
               ctl.wr_z = 1'b1;
            end
            4'h6: begin
               ctl.op = rad_pkg::RAD_OP_XOR;
               ctl.wr_z = 1'b1;
            end
            4'h7: begin
               ctl.op = rad_pkg::RAD_OP_ADD;
               {ctl.wr_c, ctl.wr_dc, ctl.wr_z} = 3'b111;
            end
            4'h8: begin
               ctl.op = rad_pkg::RAD_OP_PASS;
               ctl.wr_z = 1'b1;
            end
            4'h9: begin
               ctl.op = rad_pkg::RAD_OP_COM;
               ctl.wr_z = 1'b1;
            end
            4'ha: begin
               ctl.op = rad_pkg::RAD_OP_INC;
               ctl.wr_z = 1'b1;
            end
            4'hc: begin
               ctl.op = rad_pkg::RAD_OP_RRF;
               ctl.wr_c = 1'b1;
            end
            4'hd: begin
               ctl.op = rad_pkg::RAD_OP_RLF;
               ctl.wr_c = 1'b1;
            end
            4'he: ctl.op = rad_pkg::RAD_OP_SWAP;
            default: ctl.op = rad_pkg::RAD_OP_PASS;
         endcase
         // Sub-op 0: accumulator ORed with zero, stored to a file or kept as is
         if (sub == 4'h0) begin
            ctl.op = rad_pkg::RAD_OP_IOR;
            ctl.use_lit = 1'b1;
            ctl.lit = '0;
            ctl.wr_z = 1'b0;
            if (!instr[7]) ctl.faddr = '0;
         end
      end else if (grp == 2'b10) begin
         ctl.jump = 1'b1;
         ctl.to_file = 1'b0;
      end else if (grp == 2'b11) begin
         ctl.use_lit = 1'b1;
         ctl.to_file = 1'b0;
         unique case (sub[3:1])
            3'b000, 3'b001: ctl.op = rad_pkg::RAD_OP_PASS;
            3'b100: begin
               ctl.op = (sub[0]) ? rad_pkg::RAD_OP_AND : rad_pkg::RAD_OP_IOR;
               ctl.wr_z = 1'b1;
            end
            3'b101: begin
               ctl.op = rad_pkg::RAD_OP_XOR;
               ctl.wr_z = 1'b1;
            end
            3'b110: begin
               ctl.op = rad_pkg::RAD_OP_SUB;
               {ctl.wr_c, ctl.wr_dc, ctl.wr_z} = 3'b111;
            end
            3'b111: begin
               ctl.op = rad_pkg::RAD_OP_ADD;
               {ctl.wr_c, ctl.wr_dc, ctl.wr_z} = 3'b111;
            end
            default: ctl.op = rad_pkg::RAD_OP_PASS;
         endcase
      end else begin
         ctl.to_file = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== design/rad_core.sv ====
// Fetch/execute datapath top: program bus, file bus, accumulator, flags
`timescale 1ns/100ps
`default_nettype none
module rad_core #(
   parameter int unsigned CYCLE_CLKS = rad_pkg::ICYCLE_CLKS
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [rad_pkg::INSTR_W-1:0] prog_data,
   input wire logic [rad_pkg::DATA_W-1:0] file_rdata,
   output logic [rad_pkg::PC_W-1:0] prog_addr,
   output logic [rad_pkg::FADDR_W-1:0] file_addr,
   output logic [rad_pkg::DATA_W-1:0] file_wdata,
   output logic file_we,
   output logic [rad_pkg::DATA_W-1:0] acc_out,
   output logic [rad_pkg::DATA_W-1:0] status_out,
   output logic cycle_tick
);
   // ------------------------------------------------------------
   // Instruction cycle divider
   // ------------------------------------------------------------
   logic [7:0] div_count;
   wire logic div_end = (div_count == 8'(CYCLE_CLKS - 1));
   wire logic [7:0] next_div_count = div_end ? '0 : div_count + 8'h01;
   wire logic fetch_slot = (div_count == 8'h00);
   wire logic exec_slot = (div_count == 8'(CYCLE_CLKS / 2));

   always_ff @(posedge clock) begin
      if (reset) div_count <= '0;
      else div_count <= next_div_count;
   end

   // ------------------------------------------------------------
   // Fetch stage and pipeline register
   // ------------------------------------------------------------
   logic [rad_pkg::INSTR_W-1:0] instr_reg;
   logic [rad_pkg::INSTR_W-1:0] exec_reg;
   logic [rad_pkg::PC_W-1:0] pc;
   logic flush;
   logic exec_kill;
   logic [rad_pkg::DATA_W-1:0] acc;
   logic [rad_pkg::DATA_W-1:0] status;
   logic [rad_pkg::DATA_W-1:0] fsr;
   rad_pkg::rad_ctl_s ctl;

   // Indirect slot resolves through the pointer register
   wire logic [rad_pkg::FADDR_W-1:0] eff_addr =
      (ctl.faddr == rad_pkg::ADDR_INDIRECT) ? fsr[rad_pkg::FADDR_W-1:0] : ctl.faddr;
   wire logic is_pcl = (eff_addr == rad_pkg::ADDR_PCL);
   wire logic is_status = (eff_addr == rad_pkg::ADDR_STATUS);
   wire logic is_fsr = (eff_addr == rad_pkg::ADDR_FSR);

   // Core-held special registers read back in data space
   wire logic [rad_pkg::DATA_W-1:0] file_val =
      is_pcl ? pc[rad_pkg::DATA_W-1:0] :
      is_status ? status :
      is_fsr ? fsr : file_rdata;

   rad_decode u_decode (
      .instr(exec_reg),
      .ctl(ctl)
   );

   wire logic [rad_pkg::DATA_W-1:0] operand = ctl.use_lit ? ctl.lit : file_val;
   logic [rad_pkg::DATA_W-1:0] alu_res;
   rad_pkg::rad_flags_s alu_flags;

   rad_alu #(.WIDTH(rad_pkg::DATA_W)) u_alu (
      .op(ctl.op),
      .acc(acc),
      .opnd(operand),
      .carry_in(status[rad_pkg::FLAG_CARRY]),
      .result(alu_res),
      .flags(alu_flags)
   );

   // ------------------------------------------------------------
   // Execute write-back decisions
   // ------------------------------------------------------------
   wire logic do_exec = exec_slot && !exec_kill;
   wire logic write_file = do_exec && ctl.to_file;
   wire logic write_acc = do_exec && !ctl.to_file && !ctl.jump;
   wire logic pcl_write = write_file && is_pcl;
   wire logic take_branch = do_exec && (ctl.jump || pcl_write);
   wire logic [rad_pkg::PC_W-1:0] branch_pc = ctl.jump ? ctl.target :
      {pc[rad_pkg::PC_W-1:rad_pkg::DATA_W], alu_res};

   // Status update: a file write loads every bit, then flag bits written by the unit override it
   logic [rad_pkg::DATA_W-1:0] next_status;
   always_comb begin
      next_status = status;
      if (write_file && is_status) next_status = alu_res;
      if (do_exec && ctl.wr_c) next_status[rad_pkg::FLAG_CARRY] = alu_flags.c;
      if (do_exec && ctl.wr_dc) next_status[rad_pkg::FLAG_NIBBLE] = alu_flags.dc;
      if (do_exec && ctl.wr_z) next_status[rad_pkg::FLAG_ZERO] = alu_flags.z;
   end

   // Program counter: advance on fetch, load on branch
   wire logic [rad_pkg::PC_W-1:0] next_pc = take_branch ? branch_pc :
      (fetch_slot ? pc + 13'h0001 : pc);

   // Fetch refills the pipe each cycle; a branch marks the prefetched word stale
   always_ff @(posedge clock) begin
      if (reset) begin
         pc <= rad_pkg::PC_RESET;
         instr_reg <= rad_pkg::NOP_WORD;
         exec_reg <= rad_pkg::NOP_WORD;
         flush <= 1'b1;
         exec_kill <= 1'b1;
      end else begin
         pc <= next_pc;
         if (fetch_slot) begin
            instr_reg <= prog_data;
            exec_reg <= instr_reg;
            exec_kill <= flush;
         end
         if (take_branch) flush <= 1'b1;
         else if (fetch_slot) flush <= 1'b0;
      end
   end

   // Accumulator, pointer and status state
   always_ff @(posedge clock) begin
      if (reset) begin
         acc <= rad_pkg::BYTE_ZERO;
         fsr <= rad_pkg::BYTE_ZERO;
         status <= rad_pkg::STATUS_RESET;
      end else begin
         if (write_acc) acc <= alu_res;
         if (write_file && is_fsr) fsr <= alu_res;
         status <= next_status;
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         prog_addr <= rad_pkg::PC_RESET;
         file_addr <= '0;
         file_wdata <= rad_pkg::BYTE_ZERO;
         file_we <= 1'b0;
         acc_out <= rad_pkg::BYTE_ZERO;
         status_out <= rad_pkg::STATUS_RESET;
         cycle_tick <= 1'b0;
      end else begin
         prog_addr <= next_pc;
         file_addr <= eff_addr;
         file_wdata <= alu_res;
         file_we <= write_file;
         acc_out <= acc;
         status_out <= next_status;
         cycle_tick <= div_end;
      end
   end
endmodule
`default_nettype wire

// ==== test/rad_core_monitor.sv ====
// Port-level checks for the fetch/execute datapath top
`timescale 1ns/100ps
`default_nettype none
module rad_core_monitor #(
   parameter int unsigned CYCLE_CLKS = 4
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [13:0] prog_data,
   input wire logic [7:0] file_rdata,
   input wire logic [12:0] prog_addr,
   input wire logic [6:0] file_addr,
   input wire logic [7:0] file_wdata,
   input wire logic file_we,
   input wire logic [7:0] acc_out,
   input wire logic [7:0] status_out,
   input wire logic cycle_tick
);
   int tcnt, acnt, fcnt, wcnt, rcnt;
   logic seen;
   logic [7:0] acc_q;
   logic [2:0] flg_q;
   wire acc_chg = acc_out != acc_q;
   wire flg_chg = status_out[2:0] != flg_q;
   default clocking @(posedge clock); endclocking
   // Clocks since last tick, change, write and reset release
   always_ff @(posedge clock) begin
      acc_q <= acc_out;
      flg_q <= status_out[2:0];
      if (reset) begin
         tcnt <= 0;
         seen <= 1'b0;
         acnt <= 999;
         fcnt <= 999;
         wcnt <= 999;
         rcnt <= 0;
      end else begin
         tcnt <= cycle_tick ? 0 : tcnt + 1;
         seen <= seen | cycle_tick;
         acnt <= acc_chg ? 0 : acnt + 1;
         fcnt <= flg_chg ? 0 : fcnt + 1;
         wcnt <= file_we ? 0 : wcnt + 1;
         rcnt <= rcnt + 1;
      end
   end
   // Reset held over three edges
   sequence s_held;
      reset ##1 reset ##1 reset;
   endsequence
   property p_reset_state;
      s_held |-> prog_addr == 13'h0000 && !file_we && !cycle_tick && acc_out == 8'h00
         && status_out == 8'h18;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset values wrong");
   property p_pipe_first;
      disable iff (reset) rcnt < CYCLE_CLKS |-> !file_we && acc_out == 8'h00
         && status_out == 8'h18;
   endproperty
   a_pipe_first: assert property (p_pipe_first) else $error("early execute");
   property p_tick_period;
      disable iff (reset) seen |-> cycle_tick == (tcnt == CYCLE_CLKS - 1);
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
   property p_tick_pulse;
      disable iff (reset) $rose(cycle_tick) |=> !cycle_tick;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
   property p_we_pulse;
      disable iff (reset) file_we |=> !file_we;
   endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
   property p_we_gap;
      disable iff (reset) file_we |-> wcnt >= CYCLE_CLKS - 1;
   endproperty
   a_we_gap: assert property (p_we_gap) else $error("writes too close");
   property p_acc_gap;
      disable iff (reset) acc_chg |-> acnt >= CYCLE_CLKS - 1;
   endproperty
   a_acc_gap: assert property (p_acc_gap) else $error("acc changed twice");
   property p_flag_gap;
      disable iff (reset) flg_chg |-> fcnt >= CYCLE_CLKS - 1;
   endproperty
   a_flag_gap: assert property (p_flag_gap) else $error("flags changed twice");
endmodule
bind rad_core rad_core_monitor #(.CYCLE_CLKS(CYCLE_CLKS)) u_mon (.clock(clock), .reset(reset),
   .prog_data(prog_data), .file_rdata(file_rdata), .prog_addr(prog_addr),
   .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we), .acc_out(acc_out),
   .status_out(status_out), .cycle_tick(cycle_tick));
`default_nettype wire

// ==== test/rad_mem_model.sv ====
// Program memory and data file model facing the datapath
`timescale 1ns/100ps
`default_nettype none
module rad_mem_model #(
   parameter logic [7:0] F_INIT = 8'h3c
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [12:0] prog_addr,
   input wire logic [6:0] file_addr,
   input wire logic [7:0] file_wdata,
   input wire logic file_we,
   output logic [13:0] prog_data,
   output logic [7:0] file_rdata
);
   logic [13:0] rom [8];
   logic [7:0] regs [128];
   initial foreach (rom[i]) rom[i] = 14'h0000;
   // Both memories answer in the cycle of their address
   assign prog_data = rom[prog_addr[2:0]];
   assign file_rdata = regs[file_addr];
   // Test cell reloads on reset; writes land on the strobe
   always @(posedge clock) begin
      if (reset) begin
         regs[7'h20] <= F_INIT;
      end else if (file_we) begin
         regs[file_addr] <= file_wdata;
      end
   end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the fetch/execute datapath
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [7:0] w;
      logic [13:0] op;
      logic [7:0] acc;
      logic [2:0] flg;
      logic [7:0] fv;
   } rad_row_s;
   localparam int unsigned CYC = 4;
   logic clock, reset, file_we, cycle_tick;
   logic [13:0] prog_data;
   logic [12:0] prog_addr;
   logic [7:0] file_rdata, file_wdata, acc_out, status_out;
   logic [6:0] file_addr;
   int num_errors, num_checks;
   // Load W, one operation, result W, flags, file cell
   rad_row_s rows [16] = '{
      '{8'h0f, 14'h3ef1, 8'h00, 3'h7, 8'h3c}, '{8'h01, 14'h3c00, 8'hff, 3'h0, 8'h3c},
      '{8'h05, 14'h3c05, 8'h00, 3'h7, 8'h3c}, '{8'hf0, 14'h390f, 8'h00, 3'h4, 8'h3c},
      '{8'h50, 14'h380a, 8'h5a, 3'h0, 8'h3c}, '{8'hff, 14'h3aff, 8'h00, 3'h4, 8'h3c},
      '{8'h08, 14'h0720, 8'h44, 3'h2, 8'h3c}, '{8'h3d, 14'h02a0, 8'h3d, 3'h0, 8'hff},
      '{8'h00, 14'h09a0, 8'h00, 3'h0, 8'hc3}, '{8'h00, 14'h0a20, 8'h3d, 3'h0, 8'h3c},
      '{8'h00, 14'h03a0, 8'h00, 3'h0, 8'h3b}, '{8'h00, 14'h0da0, 8'h00, 3'h0, 8'h78},
      '{8'h00, 14'h0c20, 8'h1e, 3'h0, 8'h3c}, '{8'h00, 14'h0ea0, 8'h00, 3'h0, 8'hc3},
      '{8'ha5, 14'h00a0, 8'ha5, 3'h0, 8'ha5}, '{8'h77, 14'h01a0, 8'h77, 3'h4, 8'h00}};
   // Free-running system clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial reset = 1'b1;
   rad_core #(.CYCLE_CLKS(CYC)) dut (.clock(clock), .reset(reset), .prog_data(prog_data),
      .file_rdata(file_rdata), .prog_addr(prog_addr), .file_addr(file_addr),
      .file_wdata(file_wdata), .file_we(file_we), .acc_out(acc_out),
      .status_out(status_out), .cycle_tick(cycle_tick));
   rad_mem_model u_mod (.clock(clock), .reset(reset), .prog_addr(prog_addr),
      .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
      .prog_data(prog_data), .file_rdata(file_rdata));
   // Compare and count
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Reset, load five words, run eight instruction cycles
   task automatic run_prog(input logic [13:0] a, b, c, d, e);
      int t;
      int k;
      @(posedge clock);
      reset <= 1'b1;
      u_mod.rom[0] <= a;
      u_mod.rom[1] <= b;
      u_mod.rom[2] <= c;
      u_mod.rom[3] <= d;
      u_mod.rom[4] <= e;
      repeat (8) @(posedge clock);
      check("rst_status", 16'(status_out), 16'h0018);
      check("rst_acc", 16'(acc_out), 16'h0000);
      check("rst_pc", 16'(prog_addr), 16'h0000);
      reset <= 1'b0;
      t = 0;
      k = 0;
      while (t < 8) begin
         @(posedge clock);
         k++;
         if (cycle_tick === 1'b1) t++;
         if (k > 400) begin
            num_errors++;
            results();
         end
      end
   endtask
   initial begin
      num_errors = 0;
      num_checks = 0;
      // Table rows, each operation right behind the load of W
      foreach (rows[i]) begin
         run_prog(14'h3000 | 14'(rows[i].w), rows[i].op, 14'h2802, 14'h0000, 14'h0000);
         check("acc", 16'(acc_out), 16'(rows[i].acc));
         check("flags", 16'(status_out[2:0]), 16'(rows[i].flg));
         check("file", 16'(u_mod.regs[7'h20]), 16'(rows[i].fv));
      end
      // Branch drops its prefetched clear and lands on the second load
      run_prog(14'h2803, 14'h01a0, 14'h3011, 14'h3022, 14'h2804);
      check("br_acc", 16'(acc_out), 16'h0022);
      check("br_file", 16'(u_mod.regs[7'h20]), 16'h003c);
      // Each taken branch costs a dead cycle: only two adds land in the run
      run_prog(14'h2802, 14'h3011, 14'h3e01, 14'h2802, 14'h0000);
      check("br_time", 16'(acc_out), 16'h0002);
      check("br_time_flags", 16'(status_out[2:0]), 16'h0000);
      // Carry out of an add rotates into the file cell; Z and DC kept
      run_prog(14'h3001, 14'h3eff, 14'h0da0, 14'h2803, 14'h0000);
      check("rot_file", 16'(u_mod.regs[7'h20]), 16'h0079);
      check("rot_flags", 16'(status_out[2:0]), 16'h0006);
      results();
   end
endmodule
`default_nettype wire
